// ==== core/dpc_pkg.sv ====
// constants for the serial command engine of a 256-tap digital potentiometer
//
// Contract
// R1 - a frame is 24 clocks under chip select low; one command per frame
// R2 - host lowers chip select before first clock, raises it after last bit
// R3 - input sampled on rising clock; output changes on falling clock or select
// R4 - host waits the save time after reads, program, load and save commands
// R5 - sleep after power-up, software reset command and sleep command
// R6 - nothing but wake-up acts until wake-up opcode 0001 arrives
// R7 - sleeping keeps the wiper and ignores all commands except wake-up
// R8 - 1000 sleeps, 1001 resets to power-up state, 0000 does nothing
// R9 - opcode 0100 with channel zero loads tap register from low data byte
// R10 - opcode 0111 increments the tap register, 1111 decrements it
// R11 - opcode 1011 copies selected slot into tap register and buffer mode
// R12 - buffer mode changes only by loading a slot
// R13 - each slot holds a 9-bit word: tap value plus buffer mode bit
// R14 - opcode 1101 erases the slot; programming must follow an erase
// R15 - opcode 0010 programs slot with frame bit 8 and low data byte
// R16 - opcode 0011 saves current tap value and buffer mode into slot
// R17 - 1010 reads slot, 1100 reads tap; result leaves during next frame
// R18 - read result: mode in bit 8, value in low byte of returned frame
// R19 - host collects a read with a no-operation or another read
// R20 - host checks write protect before writing slots
// R21 - frame is msb first: opcode, slot, channel, 7 spare, mode, data
// R22 - buffer mode zero is buffer off, one is buffer on
// R23 - previous 24 received bits shift out while a new frame shifts in
// R24 - at power-up slot zero is recalled into the tap register
// R25 - increment at maximum and decrement at zero leave the tap unchanged
// R26 - only frames of exactly 24 clocks execute at chip select rise
package dpc_pkg;

    // frame layout
    localparam int unsigned FRAME_BITS = 24;
    localparam int unsigned CNT_W      = 5;
    localparam logic [4:0]  FRAME_CNT  = 5'h18;
    localparam logic [4:0]  CNT_SAT    = 5'h19;
    localparam logic [4:0]  IDX_LAST   = 5'h17;
    localparam int unsigned OPC_HI     = 23;
    localparam int unsigned OPC_LO     = 20;
    localparam int unsigned SEL_HI     = 19;
    localparam int unsigned SEL_LO     = 18;
    localparam int unsigned CHN_HI     = 17;
    localparam int unsigned CHN_LO     = 16;
    localparam int unsigned KEEP_LO    = 9;
    localparam int unsigned MODE_POS   = 8;
    localparam int unsigned DAT_HI     = 7;

    // opcodes
    localparam logic [3:0] OP_NOP    = 4'h0;
    localparam logic [3:0] OP_WAKE   = 4'h1;
    localparam logic [3:0] OP_PROG   = 4'h2;
    localparam logic [3:0] OP_SAVE   = 4'h3;
    localparam logic [3:0] OP_WRITE  = 4'h4;
    localparam logic [3:0] OP_INC    = 4'h7;
    localparam logic [3:0] OP_SLEEP  = 4'h8;
    localparam logic [3:0] OP_RESET  = 4'h9;
    localparam logic [3:0] OP_RDSLOT = 4'hA;
    localparam logic [3:0] OP_LOAD   = 4'hB;
    localparam logic [3:0] OP_RDTAP  = 4'hC;
    localparam logic [3:0] OP_ERASE  = 4'hD;
    localparam logic [3:0] OP_DEC    = 4'hF;

    // slot storage
    localparam int unsigned SLOTS     = 4;
    localparam logic [8:0]  SLOT_RST  = 9'h080;
    localparam logic [8:0]  SLOT_ERSD = 9'h1FF;
    localparam logic [7:0]  TAP_MAX   = 8'hFF;
    localparam logic [7:0]  TAP_MIN   = 8'h00;
    localparam logic [1:0]  CHAN_ZERO = 2'h0;

    // save time
    localparam int unsigned SAVE_TIME_US = 2000;
    localparam int unsigned CLK_MHZ      = 100;
    localparam int unsigned SAVE_CYCLES  = SAVE_TIME_US * CLK_MHZ;

    // power state
    typedef enum logic [1:0] {
        PW_RECALL,
        PW_SLEEP,
        PW_AWAKE
    } dpc_pwr_t;

endpackage

// ==== core/dpc_link.sv ====
// serial link shifter running on the link clock
`timescale 1ns/1ps
`default_nettype none
module dpc_link
    import dpc_pkg::*;
(
    input  wire logic                  i_rst,      // async reset, high
    input  wire logic                  i_spi_clk,  // link clock
    input  wire logic                  i_cs_n,     // chip select, low active
    input  wire logic                  i_sdi,      // serial in
    input  wire logic [FRAME_BITS-1:0] i_tx_word,  // word to return, held
    output logic      [FRAME_BITS-1:0] o_rx_word,  // last received word
    output logic      [CNT_W-1:0]      o_rx_count, // clocks in last frame
    output logic                       o_sdo       // serial out
);

    logic [FRAME_BITS-1:0] rx_q;
    logic [CNT_W-1:0]      cnt_q;
    logic                  fresh_q;
    logic [CNT_W-1:0]      idx_q;
    wire                   idle_rst = i_rst | i_cs_n;
    wire  [CNT_W-1:0]      cnt_inc  = (cnt_q == CNT_SAT) ? CNT_SAT : cnt_q + 5'h01;
    wire  [CNT_W-1:0]      idx_sel  = IDX_LAST - idx_q;

    // marks first rising edge of a frame; set by select high, cleared by the first rising edge
    always_ff @(posedge i_spi_clk or posedge idle_rst) begin
        if (idle_rst) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    // sample msb first on rising edges, count clocks saturating [R3] [R21]
    always_ff @(posedge i_spi_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_q  <= '0;
            cnt_q <= '0;
        end else if (!i_cs_n) begin
            rx_q  <= {rx_q[FRAME_BITS-2:0], i_sdi};
            cnt_q <= fresh_q ? 5'h01 : cnt_inc; // [R1]
        end
    end

    // output bit index advances on falling edges, restarts with select [R3]
    always_ff @(negedge i_spi_clk or posedge idle_rst) begin
        if (idle_rst) begin
            idx_q <= '0;
        end else if (idx_q != IDX_LAST) begin
            idx_q <= idx_q + 5'h01;
        end
    end

    // return word leaves msb first while the new one comes in [R23]
    assign o_sdo      = i_tx_word[idx_sel];
    assign o_rx_word  = rx_q;
    assign o_rx_count = cnt_q;

endmodule // dpc_link
`default_nettype wire

// ==== core/dpc_engine.sv ====
// command engine top: link, frame decode, tap register and slots
`timescale 1ns/1ps
`default_nettype none
module dpc_engine
    import dpc_pkg::*;
#(
    parameter int unsigned P_SAVE_CYCLES = SAVE_CYCLES // save time in clocks
) (
    input  wire logic       i_sys_clk,  // system clock, 100 MHz
    input  wire logic       i_rst,      // async reset, high
    input  wire logic       i_spi_clk,  // link clock
    input  wire logic       i_cs_n,     // chip select, low active
    input  wire logic       i_sdi,      // serial data in
    input  wire logic       i_wp_n,     // write protect, low protects
    output logic            o_sdo,      // serial data out
    output logic            o_sdo_oe_n, // serial out enable, low drives
    output logic [7:0]      o_tap,      // wiper position
    output logic            o_buf_on,   // output buffer on
    output logic            o_sleep,    // device sleeping
    output logic            o_busy      // slot access or tap read in progress
);

    // link side wires
    logic [FRAME_BITS-1:0] rx_word;
    logic [CNT_W-1:0]      rx_count;
    logic [FRAME_BITS-1:0] tx_q;

    // serial shifter in the link clock domain
    dpc_link u_link (
        .i_rst      (i_rst),
        .i_spi_clk  (i_spi_clk),
        .i_cs_n     (i_cs_n),
        .i_sdi      (i_sdi),
        .i_tx_word  (tx_q),
        .o_rx_word  (rx_word),
        .o_rx_count (rx_count),
        .o_sdo      (o_sdo)
    );

    // pin drives only while selected
    assign o_sdo_oe_n = i_cs_n;

    // synchronisers for select and write protect
    logic [1:0] cs_sync_q;
    logic       cs_prev_q;
    logic [1:0] wp_sync_q;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cs_sync_q <= 2'h3;
            cs_prev_q <= 1'b1;
            wp_sync_q <= 2'h0;
        end else begin
            cs_sync_q <= {cs_sync_q[0], i_cs_n};
            cs_prev_q <= cs_sync_q[1];
            wp_sync_q <= {wp_sync_q[0], i_wp_n};
        end
    end

    // frame end is the synchronised select rise; link word is still then
    wire frame_end = cs_sync_q[1] & ~cs_prev_q;
    wire len_ok    = (rx_count == FRAME_CNT);   // [R26]
    wire wr_ok     = wp_sync_q[1];

    // field split of the received frame
    wire [3:0] opc   = rx_word[OPC_HI:OPC_LO];
    wire [1:0] sel   = rx_word[SEL_HI:SEL_LO];
    wire [1:0] chan  = rx_word[CHN_HI:CHN_LO];
    wire       dbit  = rx_word[MODE_POS];
    wire [7:0] dat   = rx_word[DAT_HI:0];

    // state registers
    dpc_pwr_t pwr_q;
    dpc_pwr_t pwr_d;
    logic [7:0]  tap_q;
    logic [7:0]  tap_d;
    logic        mode_q;
    logic        mode_d;
    logic [8:0]  slot_q [SLOTS];
    logic        ersd_q [SLOTS];
    logic [17:0] busy_q;

    // a frame counts only if it is whole and the save time counter is idle
    wire frame_ok = frame_end & len_ok & (busy_q == 18'h00000); // [R1]
    wire awake    = (pwr_q == PW_AWAKE);
    wire chan_ok  = (chan == CHAN_ZERO);
    wire act      = frame_ok & awake & chan_ok;     // [R6] [R7]

    // opcode decode
    wire is_wake  = frame_ok & (opc == OP_WAKE);    // [R6]
    wire is_sleep = frame_ok & awake & (opc == OP_SLEEP);  // [R8]
    wire is_reset = frame_ok & awake & (opc == OP_RESET);  // [R8]
    wire is_write = act & (opc == OP_WRITE);        // [R9]
    wire is_inc   = act & (opc == OP_INC);          // [R10]
    wire is_dec   = act & (opc == OP_DEC);          // [R10]
    wire is_load  = act & (opc == OP_LOAD);         // [R11]
    wire is_erase = act & (opc == OP_ERASE) & wr_ok;  // [R14]
    wire is_prog  = act & (opc == OP_PROG) & wr_ok;   // [R15]
    wire is_save  = act & (opc == OP_SAVE) & wr_ok;   // [R16]
    wire is_rdslt = act & (opc == OP_RDSLOT);       // [R17]
    wire is_rdtap = act & (opc == OP_RDTAP);        // [R17]

    // commands that start an internal slot access or a tap read
    wire nv_start = is_load | is_erase | is_prog | is_save | is_rdslt | is_rdtap;

    // selected slot contents
    wire [8:0] slot_sel = slot_q[sel];
    wire [8:0] slot_zero = slot_q[0];

    // word written into a slot by program or save [R13]
    wire [8:0] prog_word = {dbit, dat};             // [R15]
    wire [8:0] save_word = {mode_q, tap_q};         // [R16]

    // saturating step of the tap register
    wire [7:0] tap_up = (tap_q == TAP_MAX) ? tap_q : tap_q + 8'h01;  // [R25]
    wire [7:0] tap_dn = (tap_q == TAP_MIN) ? tap_q : tap_q - 8'h01;  // [R25]

    // power state sequencing
    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            PW_RECALL: begin
                pwr_d = PW_SLEEP;                   // [R5]
            end
            PW_SLEEP: begin
                if (is_wake) begin
                    pwr_d = PW_AWAKE;               // [R6]
                end
            end
            PW_AWAKE: begin
                if (is_sleep) begin
                    pwr_d = PW_SLEEP;               // [R5] [R8]
                end else if (is_reset) begin
                    pwr_d = PW_RECALL;              // [R5] [R8]
                end
            end
            default: begin
                pwr_d = PW_RECALL;
            end
        endcase
    end

    // next tap value and buffer mode
    always_comb begin
        tap_d  = tap_q;
        mode_d = mode_q;
        if (pwr_q == PW_RECALL) begin
            tap_d  = slot_zero[DAT_HI:0];           // [R24]
            mode_d = slot_zero[MODE_POS];
        end else if (is_write) begin
            tap_d = dat;                            // [R9] [R12]
        end else if (is_inc) begin
            tap_d = tap_up;                         // [R10] [R12]
        end else if (is_dec) begin
            tap_d = tap_dn;                         // [R10] [R12]
        end else if (is_load) begin
            tap_d  = slot_sel[DAT_HI:0];            // [R11]
            mode_d = slot_sel[MODE_POS];            // [R12] [R22]
        end
    end

    // power state, tap register and buffer mode
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pwr_q  <= PW_RECALL;
            tap_q  <= SLOT_RST[DAT_HI:0];
            mode_q <= SLOT_RST[MODE_POS];
        end else begin
            pwr_q  <= pwr_d;
            tap_q  <= tap_d;
            mode_q <= mode_d;
        end
    end

    // slot storage; program only lands on an erased slot
    genvar gi;
    generate
        for (gi = 0; gi < SLOTS; gi++) begin : g_slot
            wire hit    = (sel == 2'(gi));
            wire er_hit = is_erase & hit;
            wire pr_hit = (is_prog | is_save) & hit & ersd_q[gi];
            always_ff @(posedge i_sys_clk or posedge i_rst) begin
                if (i_rst) begin
                    slot_q[gi] <= SLOT_RST;
                    ersd_q[gi] <= 1'b0;
                end else if (er_hit) begin
                    slot_q[gi] <= SLOT_ERSD;        // [R14]
                    ersd_q[gi] <= 1'b1;
                end else if (pr_hit) begin
                    slot_q[gi] <= is_prog ? prog_word : save_word; // [R13] [R14]
                    ersd_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // save time counter; frames are dropped while it runs
    wire [17:0] save_load = P_SAVE_CYCLES[17:0];

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            busy_q <= '0;
        end else if (nv_start) begin
            busy_q <= save_load;                    // [R4]
        end else if (busy_q != 18'h00000) begin
            busy_q <= busy_q - 18'h00001;
        end
    end

    // return word for the next frame: read result or echo of this frame
    wire [8:0] rd_word = is_rdslt ? slot_sel : {mode_q, tap_q};
    wire       rd_any  = is_rdslt | is_rdtap;
    wire [FRAME_BITS-1:0] tx_d = rd_any ?
        {rx_word[FRAME_BITS-1:KEEP_LO], rd_word} :  // [R17] [R18]
        rx_word;                                    // [R23]

    // updated only at a whole frame's end, held through the next frame
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_q <= '0;
        end else if (frame_end & len_ok) begin
            tx_q <= tx_d;
        end
    end

    // status outputs
    assign o_tap    = tap_q;
    assign o_buf_on = mode_q;                       // [R22]
    assign o_sleep  = (pwr_q != PW_AWAKE);
    assign o_busy   = (busy_q != 18'h00000);

endmodule // dpc_engine
`default_nettype wire

// ==== bench/dpc_asserts.sv ====
// port assertions for the command engine
`timescale 1ns/1ps
`default_nettype none
module dpc_asserts
    import dpc_pkg::*;
#(
    parameter int unsigned P_SAVE_CYCLES = SAVE_CYCLES // save time
) (
    input wire logic       i_sys_clk,  // sys clock
    input wire logic       i_rst,      // reset
    input wire logic       i_spi_clk,  // link clock
    input wire logic       i_cs_n,     // select
    input wire logic       i_sdi,      // serial in
    input wire logic       i_wp_n,     // protect
    input wire logic       o_sdo,      // serial out
    input wire logic       o_sdo_oe_n, // out enable
    input wire logic [7:0] o_tap,      // wiper
    input wire logic       o_buf_on,   // buffer mode
    input wire logic       o_sleep,    // asleep
    input wire logic       o_busy      // busy
);
    logic        cs_q;
    logic [7:0]  gap_q;
    logic [31:0] busy_q;
    // cycles since select rose, cycles of busy
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cs_q   <= 1'b1;
            gap_q  <= 8'hFF;
            busy_q <= 32'h0;
        end else begin
            cs_q   <= i_cs_n;
            gap_q  <= (i_cs_n && !cs_q) ? 8'h00 : gap_q + {7'h00, gap_q != 8'hFF};
            busy_q <= o_busy ? busy_q + 32'h1 : 32'h0;
        end
    end
    sequence s_sel_low; !i_cs_n [*5]; endsequence
    sequence s_busy_run; o_busy [*8]; endsequence
    property p_oe;
        @(posedge i_sys_clk) disable iff (i_rst) o_sdo_oe_n == i_cs_n;
    endproperty
    property p_gap;
        @(posedge i_sys_clk) disable iff (i_rst)
        !$stable(o_tap) || !$stable(o_buf_on) || !$stable(o_sleep) |-> gap_q <= 8'h0C;
    endproperty
    property p_sel;
        @(posedge i_sys_clk) disable iff (i_rst) s_sel_low |-> $stable(o_tap) && $stable(o_sleep);
    endproperty
    property p_busy_len;
        @(posedge i_sys_clk) disable iff (i_rst) o_busy |-> busy_q < P_SAVE_CYCLES + 2;
    endproperty
    property p_busy_min;
        @(posedge i_sys_clk) disable iff (i_rst) $rose(o_busy) |-> s_busy_run;
    endproperty
    property p_busy_hold;
        @(posedge i_sys_clk) disable iff (i_rst)
        o_busy && $past(o_busy) && $past(o_busy, 3) |-> $stable(o_tap) && $stable(o_buf_on);
    endproperty
    property p_sleep_hold;
        @(posedge i_sys_clk) disable iff (i_rst)
        o_sleep && $past(o_sleep) && $past(o_sleep, 2) |-> $stable(o_tap) && $stable(o_buf_on);
    endproperty
    property p_rst;
        @(posedge i_sys_clk) disable iff (i_rst)
        $fell(i_rst) |-> o_sleep && !o_busy && o_tap == SLOT_RST[7:0];
    endproperty
    a_oe: assert property (p_oe) else $error("sdo enable not select");
    a_gap: assert property (p_gap) else $error("change outside frame end");
    a_sel: assert property (p_sel) else $error("change during frame");
    a_busy_len: assert property (p_busy_len) else $error("busy too long");
    a_busy_min: assert property (p_busy_min) else $error("busy too short");
    a_busy_hold: assert property (p_busy_hold) else $error("tap moved while busy");
    a_sleep_hold: assert property (p_sleep_hold) else $error("tap moved asleep");
    a_rst: assert property (p_rst) else $error("bad reset state");
endmodule // dpc_asserts
bind dpc_engine dpc_asserts #(.P_SAVE_CYCLES(P_SAVE_CYCLES)) u_dpc_asserts (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_spi_clk(i_spi_clk), .i_cs_n(i_cs_n),
    .i_sdi(i_sdi), .i_wp_n(i_wp_n), .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n),
    .o_tap(o_tap), .o_buf_on(o_buf_on), .o_sleep(o_sleep), .o_busy(o_busy)
);
`default_nettype wire

// ==== bench/dpc_host_model.sv ====
// host model: sends command frames on the link
`timescale 1ns/1ps
`default_nettype none
module dpc_host_model (
    output var logic o_cs_n,    // select
    output var logic o_spi_clk, // link clock, idle low
    output var logic o_sdi,     // serial to device
    input wire logic i_sdo      // serial from device
);
    initial begin
        o_cs_n = 1'b1;
        o_spi_clk = 1'b0;
        o_sdi = 1'b0;
    end
    // frame of n clocks at 80 ns, return word sampled on rising edges
    task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] r);
        r = 24'h0;
        o_cs_n = 1'b0; // select before first clock
        #100;
        for (int k = 0; k < n; k++) begin
            o_sdi = (k < 24) ? w[23 - k] : ~o_sdi; // msb first
            #40 o_spi_clk = 1'b1; // sdi held over rising edge
            r = {r[22:0], i_sdo};
            #40 o_spi_clk = 1'b0;
        end
        #100 o_cs_n = 1'b1; // released after last bit
        o_sdi = ~o_sdi; // no stale level between frames
        #700;
    endtask
endmodule // dpc_host_model
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the command engine
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dpc_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        wp_n = 1'b1;
    logic        spi_clk;
    logic        cs_n;
    logic        sdi;
    logic        sdo;
    logic        buf_on;
    logic        sleep;
    logic        busy;
    logic        sdo_oe_n;
    logic [7:0]  tap;
    logic [23:0] rx;
    int          n_fail = 0;
    int          n_tests = 0;
    // 100 MHz system clock
    always #5 sys_clk = ~sys_clk;
    dpc_engine #(.P_SAVE_CYCLES(20)) u_dpc_engine (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_spi_clk(spi_clk), .i_cs_n(cs_n),
        .i_sdi(sdi), .i_wp_n(wp_n), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .o_tap(tap),
        .o_buf_on(buf_on), .o_sleep(sleep), .o_busy(busy)
    );
    dpc_host_model u_dpc_host_model (.o_cs_n(cs_n), .o_spi_clk(spi_clk), .o_sdi(sdi), .i_sdo(sdo));
    // compare and count
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one frame, then bounded wait for busy low
    task automatic cmd(input logic [3:0] op, input logic [1:0] sel, input logic [8:0] d,
                       input int n = 24, input logic [1:0] chn = 2'h0);
        u_dpc_host_model.xfer({op, sel, chn, 7'h00, d}, n, rx);
        for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge sys_clk);
        chk("busy", 24'h0, busy);
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // reset state, sleeping filter, wake
    task automatic t_sleep();
        chk("tap", 24'h80, tap);
        chk("sleep", 24'h1, sleep);
        chk("buf", 24'h0, buf_on);
        chk("oe", 24'h1, sdo_oe_n);
        cmd(OP_WRITE, 2'h0, 9'h05A);
        chk("echo", 24'h0, rx);
        chk("tap", 24'h80, tap);
        cmd(OP_WAKE, 2'h3, 9'h1FF);
        chk("echo", 24'h40005A, rx);
        chk("sleep", 24'h0, sleep);
    endtask
    // write, step and saturation, channel and length filters
    task automatic t_tap();
        cmd(OP_WRITE, 2'h0, 9'h1FF);
        chk("tap", 24'hFF, tap);
        cmd(OP_INC, 2'h0, 9'h0);
        chk("tap", 24'hFF, tap);
        cmd(OP_DEC, 2'h0, 9'h0);
        chk("tap", 24'hFE, tap);
        cmd(OP_WRITE, 2'h0, 9'h000);
        cmd(OP_DEC, 2'h0, 9'h0);
        chk("tap", 24'h0, tap);
        cmd(OP_INC, 2'h0, 9'h0);
        chk("tap", 24'h1, tap);
        cmd(OP_WRITE, 2'h0, 9'h033, 24, 2'h1);
        chk("tap", 24'h1, tap);
        cmd(OP_WRITE, 2'h0, 9'h033, 23);
        cmd(OP_WRITE, 2'h0, 9'h033, 25);
        chk("tap", 24'h1, tap);
        chk("buf", 24'h0, buf_on);
    endtask
    // erase, program, read, load, save, protect
    task automatic t_slots();
        cmd(OP_ERASE, 2'h2, 9'h0);
        chk("echo", 24'h410033, rx);
        cmd(OP_PROG, 2'h2, 9'h13C);
        cmd(OP_RDSLOT, 2'h2, 9'h0);
        cmd(OP_NOP, 2'h0, 9'h0);
        chk("slot2", 24'hA8013C, rx);
        cmd(OP_LOAD, 2'h2, 9'h0);
        chk("tap", 24'h3C, tap);
        chk("buf", 24'h1, buf_on);
        cmd(OP_WRITE, 2'h0, 9'h011);
        chk("buf", 24'h1, buf_on);
        cmd(OP_ERASE, 2'h1, 9'h0);
        cmd(OP_SAVE, 2'h1, 9'h0);
        cmd(OP_RDSLOT, 2'h1, 9'h0);
        cmd(OP_RDTAP, 2'h0, 9'h0);
        chk("slot1", 24'hA40111, rx);
        cmd(OP_NOP, 2'h0, 9'h0);
        chk("rdtap", 24'hC00111, rx);
        @(posedge sys_clk) wp_n <= 1'b0;
        cmd(OP_ERASE, 2'h3, 9'h0);
        cmd(OP_RDSLOT, 2'h3, 9'h0);
        @(posedge sys_clk) wp_n <= 1'b1;
        cmd(OP_NOP, 2'h0, 9'h0);
        chk("slot3", 24'hAC0080, rx);
        cmd(OP_ERASE, 2'h3, 9'h0);
        cmd(OP_RDSLOT, 2'h3, 9'h0);
        cmd(OP_NOP, 2'h0, 9'h0);
        chk("slot3", 24'hAC01FF, rx);
    endtask
    // sleep, nop and software reset
    task automatic t_power();
        cmd(OP_SLEEP, 2'h0, 9'h0);
        chk("sleep", 24'h1, sleep);
        cmd(OP_RESET, 2'h0, 9'h0);
        chk("tap", 24'h11, tap);
        cmd(OP_WAKE, 2'h0, 9'h0);
        cmd(OP_NOP, 2'h0, 9'h0);
        chk("tap", 24'h11, tap);
        cmd(OP_RESET, 2'h0, 9'h0);
        chk("sleep", 24'h1, sleep);
        chk("tap", 24'h80, tap);
        chk("buf", 24'h0, buf_on);
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        t_sleep();
        t_tap();
        t_slots();
        t_power();
        report_and_stop();
    end
    // watchdog well past the expected run
    initial begin
        #500000;
        n_fail++;
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
